//--- rtl/hwa_params.svh
// Constants of the host watchdog and alert block
`ifndef HWA_PARAMS_SVH
`define HWA_PARAMS_SVH

// ********************************************
// Override control register layout
// ********************************************
`define HWA_OVR_SWITCH_BIT   6
`define HWA_OVR_BALANCE_BIT  5
`define HWA_OVR_LOAD_BIT     4
`define HWA_OVR_CHARGE_BIT   3
`define HWA_OVR_SCAN_BIT     2
`define HWA_OVR_RESET        5'h00

// ********************************************
// Other fields
// ********************************************
`define HWA_WDT_MSB          7
`define HWA_WDT_LSB          3
`define HWA_NVM_EN_BIT       0
`define HWA_CELLF_SEL_BIT    7
`define HWA_OWIRE_SEL_BIT    0

// ********************************************
// Serial target address, upper six bits
// ********************************************
`define HWA_ADDR_UPPER       6'h14

// ********************************************
// Timing
// ********************************************
`define HWA_CLK_MHZ          125
`define HWA_PULSE_NS         1000
`define HWA_PULSE_CYC        ((`HWA_PULSE_NS * `HWA_CLK_MHZ) / 1000)
`define HWA_SEC_CYC          125000000

`endif

//--- rtl/hwa_pkg.sv
// Types of the host watchdog and alert block
`default_nettype none

package hwa_pkg;

  typedef enum logic [1:0] {
    SIdle = 2'b00,
    SAddr = 2'b01,
    SData = 2'b10,
    SAck  = 2'b11
  } hwa_link_e;

  // Host override bits, in register order 6 down to 2
  typedef struct packed {
    logic sw;
    logic bal;
    logic ld;
    logic ch;
    logic scan;
  } hwa_ovr_s;

  typedef struct packed {
    logic      sclS1;
    logic      sclS2;
    logic      sclPrev;
    logic      sdaS1;
    logic      sdaS2;
    logic      sdaPrev;
    logic      tglS1;
    logic      tglS2;
    logic      tglPrev;
    logic      strapS1;
    logic      strapS2;
    logic [1:0] strapAge;
    logic      strapDone;
    logic      addrLsb;
    hwa_link_e st;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    logic      rnw;
    logic      ackDrive;
    logic      hostSeen;
    hwa_ovr_s  ovr;
    logic      nvmEn;
    logic [26:0] secCnt;
    logic [4:0] wdSecs;
    logic      timedOut;
    logic [7:0] pulseCnt;
    logic      alertN;
    logic [7:0] cbOut;
    logic [1:0] swOut;
    logic      fatal;
  } hwa_state_s;

endpackage

`default_nettype wire

//--- rtl/hwa_host_watchdog.sv
// Host watchdog, alert output, serial target address match and fatal output
`timescale 1ns/1ps
`include "hwa_params.svh"
`default_nettype none

module hwa_host_watchdog #(
  parameter int SEC_CYCLES = `HWA_SEC_CYC,
  parameter int CELLS      = 8
) (
  // Clocks and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       sclLinkClk,
  // Serial link pins
  input  wire logic       serialDataInPin,
  output logic            serialDataOutPin,
  output logic            serialDataOutEn,
  input  wire logic       addrStrapPin,
  // Override and NVM window control, written by the register file
  input  wire logic       ctrlWrite,
  input  wire logic [7:0] ctrlWriteData,
  input  wire logic       nvmWrite,
  input  wire logic [7:0] nvmWriteData,
  output hwa_pkg::hwa_ovr_s hostOverrides,
  output logic            nvmWindowEnable,
  // Watchdog configuration and status
  input  wire logic [7:0] wdtConfig,
  output logic            timedOut,
  output logic            hostAlertN,
  // Switch requests and gated drives
  input  wire logic [CELLS-1:0] hostBalanceReq,
  input  wire logic [CELLS-1:0] autoBalanceReq,
  input  wire logic [1:0] switchReq,
  output logic [CELLS-1:0] balanceOutputs,
  output logic [1:0]      switchDrive,
  // Fatal fault output
  input  wire logic       cellOvervoltageLockout,
  input  wire logic       cellFail,
  input  wire logic       openWireFail,
  input  wire logic [7:0] fatalConfig,
  output logic            packFatalOut
);

  localparam int PULSE_CYC = `HWA_PULSE_CYC;

  if (CELLS != 8 || SEC_CYCLES < 2 * PULSE_CYC + 2 ||
      SEC_CYCLES >= (1 << 27))
  begin : g_param_check
    $error("hwa_host_watchdog: unsupported parameters");
  end

  // ********************************************
  // Link domain
  // ********************************************
  // Each rising edge captures a bit and flips a toggle. The bit stays
  // still until the next rising edge, far longer than the crossing of
  // the toggle takes, so the ref side reads it once the toggle arrives.
  logic linkBit;
  logic linkTgl;

  always_ff @(posedge sclLinkClk or posedge rst)
  begin
    if (rst)
    begin
      linkBit <= 1'b1;
      linkTgl <= 1'b0;
    end
    else
    begin
      linkBit <= serialDataInPin;
      linkTgl <= ~linkTgl;
    end
  end

  // ********************************************
  // Reference domain
  // ********************************************
  hwa_pkg::hwa_state_s s;
  hwa_pkg::hwa_state_s next_s;

  function automatic logic anySet(input hwa_pkg::hwa_ovr_s o);
    anySet = |o;
  endfunction

  logic       sclRise;
  logic       sclFall;
  logic       startCond;
  logic       stopCond;
  logic       bitEvent;
  logic [7:0] shifted;
  logic       addrMatch;
  logic       anyOvr;
  logic [4:0] wdtField;
  logic       secTick;
  logic       fatalCond;

  always_comb
  begin
    sclRise   = s.sclS2 & ~s.sclPrev;
    sclFall   = ~s.sclS2 & s.sclPrev;
    startCond = s.sclS2 & s.sclPrev & s.sdaPrev & ~s.sdaS2;
    stopCond  = s.sclS2 & s.sclPrev & ~s.sdaPrev & s.sdaS2;
    bitEvent  = s.tglS2 ^ s.tglPrev;
    shifted   = {s.shift[6:0], linkBit};
    addrMatch = shifted[7:1] == {`HWA_ADDR_UPPER, s.addrLsb};
    anyOvr    = anySet(s.ovr);
    wdtField  = wdtConfig[`HWA_WDT_MSB:`HWA_WDT_LSB];
    secTick   = s.secCnt == 27'(SEC_CYCLES - 1);
    fatalCond = cellOvervoltageLockout
              | (fatalConfig[`HWA_CELLF_SEL_BIT] & cellFail)
              | (fatalConfig[`HWA_OWIRE_SEL_BIT] & openWireFail);
  end

  always_comb
  begin
    next_s = s;
    // Synchronisers; first stages feed only second stages
    next_s.sclS1   = sclLinkClk;
    next_s.sclS2   = s.sclS1;
    next_s.sclPrev = s.sclS2;
    next_s.sdaS1   = serialDataInPin;
    next_s.sdaS2   = s.sdaS1;
    next_s.sdaPrev = s.sdaS2;
    next_s.tglS1   = linkTgl;
    next_s.tglS2   = s.tglS1;
    next_s.tglPrev = s.tglS2;
    next_s.strapS1 = addrStrapPin;
    next_s.strapS2 = s.strapS1;
    next_s.hostSeen = 1'b0;

    // Strap caught once after reset release, then frozen
    if (!s.strapDone)
    begin
      next_s.strapAge = s.strapAge + 2'd1;
      // Wait out both sync stages, else the reset value gets caught
      if (s.strapAge == 2'd2)
      begin
        next_s.strapDone = 1'b1;
        next_s.addrLsb   = s.strapS2;
      end
    end

    // ********************************************
    // Serial target
    // ********************************************
    case (s.st)
      hwa_pkg::SIdle:
      begin
        next_s.ackDrive = 1'b0;
      end
      hwa_pkg::SAddr, hwa_pkg::SData:
      begin
        if (bitEvent)
        begin
          next_s.shift  = shifted;
          next_s.bitCnt = s.bitCnt + 3'd1;
          if (s.bitCnt == 3'd7)
          begin
            if (s.st == hwa_pkg::SData)
              next_s.st = hwa_pkg::SAck;
            else if (addrMatch)
            begin
              next_s.st  = hwa_pkg::SAck;
              next_s.rnw = shifted[0];
              next_s.hostSeen = 1'b1;
            end
            else
              next_s.st = hwa_pkg::SIdle;
          end
        end
      end
      hwa_pkg::SAck:
      begin
        if (sclFall)
        begin
          if (!s.ackDrive)
            next_s.ackDrive = 1'b1;
          else
          begin
            // Reads return released data; no readable map lives here
            next_s.ackDrive = 1'b0;
            next_s.bitCnt   = 3'd0;
            next_s.st = s.rnw ? hwa_pkg::SIdle : hwa_pkg::SData;
          end
        end
      end
      default:
      begin
        next_s.st = hwa_pkg::SIdle;
      end
    endcase
    if (startCond)
    begin
      next_s.st       = hwa_pkg::SAddr;
      next_s.bitCnt   = 3'd0;
      next_s.ackDrive = 1'b0;
    end
    else if (stopCond)
    begin
      next_s.st       = hwa_pkg::SIdle;
      next_s.ackDrive = 1'b0;
    end

    // ********************************************
    // Watchdog
    // ********************************************
    next_s.secCnt = secTick ? 27'd0 : s.secCnt + 27'd1;
    if (secTick && s.wdSecs != 5'h1f)
      next_s.wdSecs = s.wdSecs + 5'd1;
    // Field value zero leaves the watchdog disarmed
    if (secTick && wdtField != 5'd0 && s.wdSecs + 5'd1 >= wdtField)
      next_s.timedOut = 1'b1;
    if (s.pulseCnt != 8'd0)
      next_s.pulseCnt = s.pulseCnt - 8'd1;
    if (secTick && (s.timedOut || next_s.timedOut))
      next_s.pulseCnt = 8'(PULSE_CYC);
    if (s.hostSeen)
    begin
      next_s.secCnt = 27'd0;
      next_s.wdSecs = 5'd0;
      if (s.timedOut)
      begin
        next_s.timedOut = 1'b0;
        next_s.pulseCnt = 8'd0;
        next_s.ovr.sw   = 1'b0;
        next_s.ovr.ld   = 1'b0;
        next_s.ovr.ch   = 1'b0;
        next_s.ovr.scan = 1'b0;
        next_s.nvmEn    = 1'b0;
      end
    end
    // Register writes land after the recovery clear
    if (ctrlWrite)
      next_s.ovr = ctrlWriteData[`HWA_OVR_SWITCH_BIT:`HWA_OVR_SCAN_BIT];
    if (nvmWrite)
      next_s.nvmEn = nvmWriteData[`HWA_NVM_EN_BIT];
    if (!anySet(next_s.ovr))
    begin
      next_s.secCnt   = 27'd0;
      next_s.wdSecs   = 5'd0;
      next_s.timedOut = 1'b0;
      next_s.pulseCnt = 8'd0;
    end
    next_s.alertN = next_s.pulseCnt == 8'd0;

    // ********************************************
    // Gated drives and fatal output
    // ********************************************
    if (next_s.timedOut)
    begin
      next_s.cbOut = '0;
      next_s.swOut = 2'b00;
    end
    else
    begin
      next_s.cbOut = next_s.ovr.bal ? hostBalanceReq
                                    : autoBalanceReq;
      next_s.swOut = switchReq;
    end
    next_s.fatal = fatalCond;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s           <= '0;
      s.sclS1     <= 1'b1;
      s.sclS2     <= 1'b1;
      s.sclPrev   <= 1'b1;
      s.sdaS1     <= 1'b1;
      s.sdaS2     <= 1'b1;
      s.sdaPrev   <= 1'b1;
      s.st        <= hwa_pkg::SIdle;
      s.ovr       <= `HWA_OVR_RESET;
      s.alertN    <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign serialDataOutPin = 1'b0;
  assign serialDataOutEn  = s.ackDrive;
  assign hostOverrides    = s.ovr;
  assign nvmWindowEnable  = s.nvmEn;
  assign timedOut         = s.timedOut;
  assign hostAlertN       = s.alertN;
  assign balanceOutputs   = s.cbOut;
  assign switchDrive      = s.swOut;
  assign packFatalOut     = s.fatal;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic [7:0] lowLen;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      lowLen <= 8'd0;
    else
      lowLen <= s.alertN ? 8'd0 : lowLen + 8'd1;
  end

  sequence ackStart;
    s.st == hwa_pkg::SAck && sclFall && !s.ackDrive && !startCond &&
    !stopCond;
  endsequence

  sequence recoverEvent;
    s.hostSeen && s.timedOut && !ctrlWrite && !nvmWrite;
  endsequence

  a_alert_idle: assert property (!anyOvr |-> s.alertN)
    else $error("alert low with no override set");
  a_pulse_len: assert property (
      $rose(s.alertN) && anyOvr && !$past(s.hostSeen)
      |-> lowLen == 8'(PULSE_CYC))
    else $error("alert pulse length wrong");
  a_timeout_alert: assert property ($rose(s.timedOut) |-> !s.alertN)
    else $error("timeout without alert");
  a_drives_off: assert property (s.timedOut
      |-> s.cbOut == '0 && s.swOut == 2'b00)
    else $error("drive on while timed out");
  a_recover_clear: assert property (recoverEvent |=> !s.timedOut &&
      !s.ovr.sw && !s.ovr.ld && !s.ovr.ch && !s.ovr.scan && !s.nvmEn &&
      s.ovr.bal == $past(s.ovr.bal))
    else $error("recovery clear wrong");
  a_wd_hold: assert property (!anyOvr |-> s.wdSecs == 5'd0 &&
      !s.timedOut)
    else $error("watchdog runs with no override");
  a_ack_drive: assert property (ackStart |=> serialDataOutEn)
    else $error("no acknowledge driven");
  a_fatal_follow: assert property (##1 s.fatal == $past(fatalCond))
    else $error("fatal output does not follow");
  a_strap_hold: assert property (s.strapDone |=> $stable(s.addrLsb))
    else $error("address bit moved");

endmodule

`default_nettype wire

//--- verification/hwa_i2c_host.sv
// Behavioural serial master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none

module hwa_i2c_host (
  // Request from the bench
  input  wire logic       go,
  input  wire logic [7:0] byte0,
  input  wire logic [7:0] byte1,
  input  wire logic       twoBytes,
  // Serial bus
  input  wire logic       sdaLine,
  output logic            scl,
  output logic            sdaLow,
  // Answer
  output logic            done,
  output logic [1:0]      acks
);
  logic tick;

  // ************************************
  // One line edge per tick keeps edges 80 ns apart
  // ************************************
  initial
  begin
    tick = 1'b0;
    #3;
    forever #40 tick = ~tick;
  end

  task automatic step;
    @(posedge tick);
  endtask

  // Byte MSB first; R/W already sits in bit 0 of the address byte
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      step;
      sdaLow = !b[i];
      step;
      scl = 1'b1;
      step;
      scl = 1'b0;
    end
    step;
    sdaLow = 1'b0;
    step;
    scl = 1'b1;
    step;
    ack = !sdaLine;
    scl = 1'b0;
  endtask

  // Clock stands high between frames
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
    done = 1'b0;
    acks = 2'h0;
    forever
    begin
      wait (go);
      step;
      sdaLow = 1'b1;
      step;
      scl = 1'b0;
      send(byte0, acks[0]);
      acks[1] = 1'b0;
      if (twoBytes)
        send(byte1, acks[1]);
      step;
      sdaLow = 1'b1;
      step;
      scl = 1'b1;
      step;
      sdaLow = 1'b0;
      done = 1'b1;
      wait (!go);
      done = 1'b0;
    end
  end
endmodule

`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench of the host watchdog and alert block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int SEC   = 400;
  localparam int LIMIT = 20000;
  logic              ref_clk, rst, strap, go, two, done, scl, sdaLow;
  logic              sdaLine, ctrlWrite, nvmWrite, cellOv, cellFail;
  logic              openWire, dOut, dOutEn, timedOut, alertN, nvmEn, fatal;
  logic [7:0]        ctrlData, nvmData, wdtConfig, fatalConfig, b0, b1;
  logic [7:0]        balReq, autoReq, balOut;
  logic [1:0]        switchReq, swDrive, acks;
  hwa_pkg::hwa_ovr_s ovr;
  int                err_total, comparisons, cycles;

  assign sdaLine = !(sdaLow || (dOutEn && !dOut));

  hwa_host_watchdog #(.SEC_CYCLES(SEC)) u_hwa_host_watchdog (
    .ref_clk(ref_clk), .rst(rst), .sclLinkClk(scl),
    .serialDataInPin(sdaLine), .serialDataOutPin(dOut),
    .serialDataOutEn(dOutEn), .addrStrapPin(strap),
    .ctrlWrite(ctrlWrite), .ctrlWriteData(ctrlData), .nvmWrite(nvmWrite),
    .nvmWriteData(nvmData), .hostOverrides(ovr), .nvmWindowEnable(nvmEn),
    .wdtConfig(wdtConfig), .timedOut(timedOut), .hostAlertN(alertN),
    .hostBalanceReq(balReq), .autoBalanceReq(autoReq),
    .switchReq(switchReq), .balanceOutputs(balOut), .switchDrive(swDrive),
    .cellOvervoltageLockout(cellOv), .cellFail(cellFail),
    .openWireFail(openWire), .fatalConfig(fatalConfig),
    .packFatalOut(fatal));

  hwa_i2c_host u_hwa_i2c_host (
    .go(go), .byte0(b0), .byte1(b1), .twoBytes(two), .sdaLine(sdaLine),
    .scl(scl), .sdaLow(sdaLow), .done(done), .acks(acks));

  // ************************************
  // Shared tasks
  // ************************************
  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_total++;
      report_and_stop;
    end
  end

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wr(input logic nvm, input logic [7:0] d);
    ctrlData = d;
    nvmData = d;
    ctrlWrite = !nvm;
    nvmWrite = nvm;
    cyc(1);
    ctrlWrite = 1'b0;
    nvmWrite = 1'b0;
    cyc(1);
  endtask

  // Request held until done is seen high at a rising edge
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic t);
    int n;
    b0 = a;
    b1 = d;
    two = t;
    go = 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (done !== 1'b1 && n < 3000);
    chk("transfer done", 1, done);
    cyc(1);
    go = 1'b0;
    cyc(2);
  endtask

  task automatic do_reset(input logic s);
    strap = s;
    rst = 1'b1;
    cyc(20);
    chk("alert in reset", 1, alertN);
    chk("timeout in reset", 0, timedOut);
    rst = 1'b0;
    cyc(6);
  endtask

  // ************************************
  // Scenarios
  // ************************************
  task automatic t_fatal;
    cellOv = 1'b1;
    cyc(1);
    cellOv = 1'b0;
    chk("fatal pulse", 1, fatal);
    cyc(1);
    chk("fatal drop", 0, fatal);
    for (int i = 0; i < 4; i++)
    begin
      fatalConfig = {i[1], 6'h00, i[0]};
      cellFail = 1'b1;
      openWire = 1'b0;
      cyc(2);
      chk("cell fail select", i[1], fatal);
      cellFail = 1'b0;
      openWire = 1'b1;
      cyc(2);
      chk("open wire select", i[0], fatal);
    end
    cellFail = 1'b0;
    openWire = 1'b0;
    cyc(2);
    chk("fatal clear", 0, fatal);
  endtask

  task automatic t_idle;
    wdtConfig = 8'h08;
    cyc(3 * SEC);
    chk("idle timeout", 0, timedOut);
    chk("idle alert", 1, alertN);
    for (int i = 2; i < 7; i++)
    begin
      wr(1'b0, 8'h01 << i);
      chk("override bit", 32'h1 << (i - 2), ovr);
    end
    wr(1'b0, 8'h00);
  endtask

  task automatic t_addr;
    xfer(8'h50, 8'h00, 1'b0);
    chk("foreign address ack", 0, acks[0]);
    xfer(8'h52, 8'h3c, 1'b1);
    chk("write acks", 3, acks);
    xfer(8'h53, 8'h00, 1'b0);
    chk("read address ack", 1, acks[0]);
  endtask

  task automatic t_watchdog;
    int n;
    int m;
    int q;
    wdtConfig = 8'h10;
    balReq = 8'ha5;
    autoReq = 8'h5a;
    switchReq = 2'h3;
    wr(1'b0, 8'h7c);
    wr(1'b1, 8'h01);
    chk("host balance", 8'ha5, balOut);
    chk("switch on", 3, swDrive);
    cyc(SEC);
    xfer(8'h52, 8'h00, 1'b0);
    n = 0;
    while (timedOut !== 1'b1 && n < 3 * SEC)
    begin
      cyc(1);
      n++;
    end
    chk("restart delay", 1, n > 2 * SEC - 150 && n <= 2 * SEC + 1);
    chk("alert on timeout", 0, alertN);
    chk("balance forced off", 0, balOut);
    chk("switches forced off", 0, swDrive);
    m = 0;
    q = 0;
    while (alertN === 1'b0 && m < SEC)
    begin
      m++;
      cyc(1);
    end
    while (alertN === 1'b1 && q < SEC)
    begin
      q++;
      cyc(1);
    end
    chk("alert low cycles", 125, m);
    chk("alert period", SEC, m + q);
    chk("turn-on held", 0, swDrive);
    chk("balance held", 0, balOut);
    cellOv = 1'b1;
    cyc(1);
    chk("fatal while timed out", 1, fatal);
    cellOv = 1'b0;
    xfer(8'h50, 8'h00, 1'b0);
    chk("still timed out", 1, timedOut);
    xfer(8'h52, 8'h00, 1'b0);
    chk("recovered", 0, timedOut);
    chk("alert released", 1, alertN);
    chk("override clear", 5'h08, ovr);
    chk("nvm clear", 0, nvmEn);
    chk("balance back", 8'ha5, balOut);
    chk("switch back", 3, swDrive);
    wr(1'b0, 8'h40);
    chk("auto balance", 8'h5a, balOut);
    wr(1'b0, 8'h00);
  endtask

  task automatic t_strap_low;
    xfer(8'h52, 8'h00, 1'b0);
    chk("strap low other", 0, acks[0]);
    xfer(8'h50, 8'h00, 1'b0);
    chk("strap low match", 1, acks[0]);
  endtask

  initial
  begin
    {ref_clk, go, two, ctrlWrite, nvmWrite, cellOv, cellFail, openWire} = 8'h00;
    {ctrlData, nvmData, wdtConfig, fatalConfig, b0, b1} = 48'h0;
    {balReq, autoReq, switchReq} = 18'h0;
    {err_total, comparisons, cycles} = 96'h0;
    rst = 1'b1;
    strap = 1'b1;
    do_reset(1'b1);
    t_fatal;
    t_idle;
    t_addr;
    t_watchdog;
    do_reset(1'b0);
    t_strap_low;
    report_and_stop;
  end
endmodule

`default_nettype wire
